// File: common/dsc_pkg.sv
// Shared constants for the dual converter serial control link and its master
package dsc_pkg;
    // Frame layout
    localparam int          FRAME_BITS   = 16;
    localparam int          CODE_W       = 12;
    localparam int          LEAD_POS     = 15;
    localparam int          ADDR_POS     = 14;
    localparam int          OP_HI_POS    = 13;
    localparam int          OP_LO_POS    = 12;
    localparam logic [3:0]  LAST_BIT     = 4'hF;
    localparam logic [4:0]  FRAME_COUNT  = 5'h10;

    // Operation field codes
    localparam logic [1:0]  OP_LOAD      = 2'h0;
    localparam logic [1:0]  OP_LOAD_UPD  = 2'h1;
    localparam logic [1:0]  OP_BOTH_UPD  = 2'h2;
    localparam logic [1:0]  OP_PWR_DOWN  = 2'h3;

    // Output termination in power-down
    localparam logic [1:0]  TERM_HIZ     = 2'h0;
    localparam logic [1:0]  TERM_2K5     = 2'h1;
    localparam logic [1:0]  TERM_100K    = 2'h2;

    // Reset values
    localparam logic [11:0] CODE_RESET   = 12'h000;

    // Link timing, clock period and least frame select high time in ns
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          SYNC_HIGH_NS  = 6;
    localparam int          SCLK_MIN_NS   = 25;
    localparam int          SYNC_HIGH_CYC = (SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          HALF_MIN_CYC  =
        (SCLK_MIN_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

    // Master register map, byte offsets, divider reset and minimum values, busy bit index
    localparam logic [7:0]  REG_CMD      = 8'h00;
    localparam logic [7:0]  REG_STATUS   = 8'h04;
    localparam logic [7:0]  REG_DIV      = 8'h08;
    localparam logic [7:0]  DIV_RESET    = 8'h08;
    localparam logic [7:0]  DIV_MIN      = 8'h04;
    localparam int          STAT_BUSY    = 0;
endpackage

// File: common/dsc_link_if.sv
// Three-wire serial link between the master and the converter control
`timescale 1ns/100ps
interface dsc_link_if;
    logic sclk;
    logic sync_n;
    logic din;

    modport dev_mp (
        input sclk,
        input sync_n,
        input din
    );

    modport host_mp (
        output sclk,
        output sync_n,
        output din
    );
endinterface

// File: rtl/dsc_device.sv
// Converter control end: serial frame capture, channel registers, power-down
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - Frame select low shifts data on falling edges
// - Master never lowers select at falling edge
// - Sixteenth falling edge executes the command
// - Extra edges ignored until select rises
// - Master holds select high before next frame
// - Master parks select and data low
// - First bit zero, second bit picks channel
// - Third and fourth bits select operation
// - Last twelve bits are code, MSB first
// - Code unsigned, output scales code over 4096
// - Early select rise discards the partial frame
// - Reset clears registers, outputs at zero
// - Operation 11 powers down both channels
// - In power-down first two bits pick termination
// - Power-down keeps channel register contents
// - Any other operation leaves power-down
module dsc_device #(
    parameter int CODE_W = dsc_pkg::CODE_W
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    dsc_link_if.dev_mp             link,
    output logic [CODE_W-1:0]      analog_out_first_code,
    output logic [CODE_W-1:0]      analog_out_second_code,
    output logic                   outputs_active,
    output logic [1:0]             term_mode,
    output logic                   exec_pulse,
    output logic                   lead_bit_err
);

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE  = 2'b10
    } dsc_dev_state_type;

    // Elaboration check on the code width
    if (CODE_W != dsc_pkg::CODE_W) begin : g_bad_width
        $error("dsc_device: CODE_W must equal the frame code field");
    end

    // Power-down termination from the two leading bits
    function automatic logic [1:0] term_decode(input logic lead, input logic addr);
        logic [1:0] t;
        t = dsc_pkg::TERM_HIZ;
        if (!lead && addr) begin
            t = dsc_pkg::TERM_2K5;
        end else if (lead && !addr) begin
            t = dsc_pkg::TERM_100K;
        end
        return t;
    endfunction

    dsc_dev_state_type         state_ff;
    dsc_dev_state_type         nxt_state;
    logic [2:0]                sclk_ff;
    logic [1:0]                sync_ff;
    logic [1:0]                din_ff;
    logic [14:0]               shreg_ff;
    logic [14:0]               nxt_shreg;
    logic [3:0]                count_ff;
    logic [3:0]                nxt_count;
    logic [CODE_W-1:0]         hold_a_ff;
    logic [CODE_W-1:0]         nxt_hold_a;
    logic [CODE_W-1:0]         hold_b_ff;
    logic [CODE_W-1:0]         nxt_hold_b;
    logic [CODE_W-1:0]         out_a_ff;
    logic [CODE_W-1:0]         nxt_out_a;
    logic [CODE_W-1:0]         out_b_ff;
    logic [CODE_W-1:0]         nxt_out_b;
    logic                      pd_ff;
    logic                      nxt_pd;
    logic                      act_ff;
    logic                      nxt_act;
    logic [1:0]                term_ff;
    logic [1:0]                nxt_term;
    logic                      exec_ff;
    logic                      nxt_exec;
    logic                      lead_err_ff;
    logic                      nxt_lead_err;
    logic                      sclk_fall;
    logic                      sync_n_s;
    logic                      din_s;
    logic [15:0]               word;
    logic                      addr_b;
    logic [1:0]                op;
    logic [CODE_W-1:0]         code;

    // Two-stage synchronisers; sclk has a third stage for edge detection
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sclk_ff <= 3'h7;  // Link clock idles high, no false edge
            sync_ff <= 2'h3;
            din_ff  <= 2'h0;
        end else begin
            sclk_ff <= {sclk_ff[1:0], link.sclk};
            sync_ff <= {sync_ff[0], link.sync_n};
            din_ff  <= {din_ff[0], link.din};
        end
    end

    // Synchronised views, first stages unread here
    assign sclk_fall = sclk_ff[2] && !sclk_ff[1];
    assign sync_n_s  = sync_ff[1];
    assign din_s     = din_ff[1];

    // Full frame word as it stands on the last falling edge
    assign word   = {shreg_ff, din_s};
    assign addr_b = word[dsc_pkg::ADDR_POS];
    assign op     = {word[dsc_pkg::OP_HI_POS], word[dsc_pkg::OP_LO_POS]};
    assign code   = word[CODE_W-1:0];

    // Frame sequencing: capture, execute strobe, abort
    always_comb begin
        nxt_state = state_ff;
        nxt_shreg = shreg_ff;
        nxt_count = count_ff;
        nxt_exec  = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (!sync_n_s) begin
                    nxt_state = ST_SHIFT;
                    nxt_count = 4'h0;
                end
            end
            ST_SHIFT: begin
                if (sync_n_s) begin
                    nxt_state = ST_IDLE;
                end else if (sclk_fall) begin
                    nxt_shreg = word[14:0];
                    if (count_ff == dsc_pkg::LAST_BIT) begin
                        nxt_exec  = 1'b1;
                        nxt_state = ST_DONE;
                    end else begin
                        nxt_count = count_ff + 4'h1;
                    end
                end
            end
            ST_DONE: begin
                if (sync_n_s) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Command execution on the completing edge
    always_comb begin
        nxt_hold_a   = hold_a_ff;
        nxt_hold_b   = hold_b_ff;
        nxt_out_a    = out_a_ff;
        nxt_out_b    = out_b_ff;
        nxt_pd       = pd_ff;
        nxt_term     = term_ff;
        nxt_lead_err = 1'b0;
        if (state_ff == ST_SHIFT && !sync_n_s && sclk_fall
            && count_ff == dsc_pkg::LAST_BIT) begin
            case (op)
                dsc_pkg::OP_PWR_DOWN: begin
                    nxt_pd   = 1'b1;
                    nxt_term = term_decode(word[dsc_pkg::LEAD_POS], addr_b);
                end
                dsc_pkg::OP_BOTH_UPD: begin
                    nxt_pd     = 1'b0;
                    nxt_hold_a = code;
                    nxt_hold_b = code;
                    nxt_out_a  = code;
                    nxt_out_b  = code;
                end
                default: begin
                    nxt_pd = 1'b0;
                    if (addr_b) begin
                        nxt_hold_b = code;
                    end else begin
                        nxt_hold_a = code;
                    end
                    if (op == dsc_pkg::OP_LOAD_UPD) begin
                        nxt_out_a = addr_b ? hold_a_ff : code;
                        nxt_out_b = addr_b ? code : hold_b_ff;
                    end
                end
            endcase
            if (op != dsc_pkg::OP_PWR_DOWN) begin
                nxt_lead_err = word[dsc_pkg::LEAD_POS];
            end
        end
        nxt_act = !nxt_pd;
    end

    // State and register storage, cleared at reset except the active flag, which is set
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff    <= ST_IDLE;
            shreg_ff    <= 15'h0000;
            count_ff    <= 4'h0;
            hold_a_ff   <= dsc_pkg::CODE_RESET;
            hold_b_ff   <= dsc_pkg::CODE_RESET;
            out_a_ff    <= dsc_pkg::CODE_RESET;
            out_b_ff    <= dsc_pkg::CODE_RESET;
            pd_ff       <= 1'b0;
            act_ff      <= 1'b1;
            term_ff     <= dsc_pkg::TERM_HIZ;
            exec_ff     <= 1'b0;
            lead_err_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            shreg_ff    <= nxt_shreg;
            count_ff    <= nxt_count;
            hold_a_ff   <= nxt_hold_a;
            hold_b_ff   <= nxt_hold_b;
            out_a_ff    <= nxt_out_a;
            out_b_ff    <= nxt_out_b;
            pd_ff       <= nxt_pd;
            act_ff      <= nxt_act;
            term_ff     <= nxt_term;
            exec_ff     <= nxt_exec;
            lead_err_ff <= nxt_lead_err;
        end
    end

    // Unsigned codes to the analog stage, scaled by reference over 4096
    assign analog_out_first_code  = out_a_ff;
    assign analog_out_second_code = out_b_ff;
    assign outputs_active         = act_ff;  // Own flop, no logic depth
    assign term_mode              = term_ff;
    assign exec_pulse             = exec_ff;
    assign lead_bit_err           = lead_err_ff;

endmodule

// File: rtl/dsc_host.sv
// Serial master end: Wishbone command registers driving the three-wire link
`timescale 1ns/100ps
module dsc_host (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output logic [31:0]      wb_dat_r,
    output logic             wb_ack,
    dsc_link_if.host_mp      link
);

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_GAP  = 3'b001,
        HS_HIGH = 3'b010,
        HS_LOW  = 3'b011,
        HS_TAIL = 3'b100
    } dsc_host_state_type;

    dsc_host_state_type state_ff;
    dsc_host_state_type nxt_state;
    logic [7:0]         cnt_ff;
    logic [7:0]         nxt_cnt;
    logic [4:0]         bits_ff;
    logic [4:0]         nxt_bits;
    logic [15:0]        shreg_ff;
    logic [15:0]        nxt_shreg;
    logic [15:0]        cmd_ff;
    logic [15:0]        nxt_cmd;
    logic [7:0]         div_ff;
    logic [7:0]         nxt_div;
    logic               sclk_ff;
    logic               nxt_sclk;
    logic               sync_ff;
    logic               nxt_sync;
    logic               din_ff;
    logic               nxt_din;
    logic               ack_ff;
    logic               nxt_ack;
    logic [31:0]        rdat_ff;
    logic [31:0]        nxt_rdat;
    logic               wr_fire;
    logic               start;
    logic               tick;
    logic [7:0]         div_wr;

    // Write commits at the edge where the master sees ack
    assign wr_fire = wb_cyc && wb_stb && wb_we && ack_ff;
    assign start   = wr_fire && wb_adr == dsc_pkg::REG_CMD && wb_sel[1:0] == 2'h3
                     && state_ff == HS_IDLE;
    assign tick    = cnt_ff == div_ff - 8'h01;
    assign div_wr  = (wb_dat_w[7:0] < dsc_pkg::DIV_MIN) ? dsc_pkg::DIV_MIN : wb_dat_w[7:0];

    // Bus slave: ack, read mux, register writes
    always_comb begin
        nxt_ack  = wb_cyc && wb_stb && !ack_ff;
        nxt_rdat = rdat_ff;
        nxt_div  = div_ff;
        nxt_cmd  = cmd_ff;
        if (nxt_ack && !wb_we) begin
            if (wb_adr == dsc_pkg::REG_CMD) begin
                nxt_rdat = {16'h0000, cmd_ff};
            end else if (wb_adr == dsc_pkg::REG_STATUS) begin
                nxt_rdat = {31'h00000000, state_ff != HS_IDLE};
            end else if (wb_adr == dsc_pkg::REG_DIV) begin
                nxt_rdat = {24'h000000, div_ff};
            end else begin
                nxt_rdat = 32'h00000000;
            end
        end
        if (wr_fire && wb_adr == dsc_pkg::REG_DIV && wb_sel[0]) begin
            nxt_div = div_wr;
        end
        if (start) begin
            nxt_cmd = wb_dat_w[15:0];
        end
    end

    // Frame generator; each tick is one half period of the serial clock
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = (state_ff == HS_IDLE || tick) ? 8'h00 : cnt_ff + 8'h01;
        nxt_bits  = bits_ff;
        nxt_shreg = shreg_ff;
        nxt_sclk  = sclk_ff;
        nxt_sync  = sync_ff;
        nxt_din   = din_ff;
        case (state_ff)
            HS_IDLE: begin
                if (start) begin
                    nxt_state = HS_GAP;
                    nxt_shreg = wb_dat_w[15:0];
                    nxt_sync  = 1'b1;
                    nxt_sclk  = 1'b1;
                    nxt_bits  = 5'h00;
                end
            end
            HS_GAP: begin
                if (tick) begin
                    nxt_state = HS_HIGH;
                    nxt_sync  = 1'b0;
                    nxt_din   = shreg_ff[15];
                end
            end
            HS_HIGH: begin
                if (tick) begin
                    nxt_state = HS_LOW;
                    nxt_sclk  = 1'b0;
                    nxt_bits  = bits_ff + 5'h01;
                end
            end
            HS_LOW: begin
                if (tick) begin
                    nxt_sclk = 1'b1;
                    if (bits_ff == dsc_pkg::FRAME_COUNT) begin
                        nxt_state = HS_TAIL;
                        nxt_sync  = 1'b1;
                    end else begin
                        nxt_state = HS_HIGH;
                        nxt_shreg = {shreg_ff[14:0], 1'b0};
                        nxt_din   = shreg_ff[14];
                    end
                end
            end
            HS_TAIL: begin
                if (tick) begin
                    nxt_state = HS_IDLE;
                    nxt_sync  = 1'b0;
                    nxt_din   = 1'b0;
                end
            end
            default: begin
                nxt_state = HS_IDLE;
            end
        endcase
    end

    // Registers; link parks with select and data low, clock high
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= HS_IDLE;
            cnt_ff   <= 8'h00;
            bits_ff  <= 5'h00;
            shreg_ff <= 16'h0000;
            cmd_ff   <= 16'h0000;
            div_ff   <= dsc_pkg::DIV_RESET;
            sclk_ff  <= 1'b1;
            sync_ff  <= 1'b0;
            din_ff   <= 1'b0;
            ack_ff   <= 1'b0;
            rdat_ff  <= 32'h00000000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            bits_ff  <= nxt_bits;
            shreg_ff <= nxt_shreg;
            cmd_ff   <= nxt_cmd;
            div_ff   <= nxt_div;
            sclk_ff  <= nxt_sclk;
            sync_ff  <= nxt_sync;
            din_ff   <= nxt_din;
            ack_ff   <= nxt_ack;
            rdat_ff  <= nxt_rdat;
        end
    end

    assign link.sclk   = sclk_ff;
    assign link.sync_n = sync_ff;
    assign link.din    = din_ff;
    assign wb_ack      = ack_ff;
    assign wb_dat_r    = rdat_ff;

endmodule

// File: verification/dsc_link_asserts.sv
// Concurrent checks on the serial link, the converter outputs and the bus answer
`timescale 1ns/100ps
module dsc_link_asserts (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        sclk,
    input wire logic        sync_n,
    input wire logic        din,
    input wire logic        wb_cyc,
    input wire logic        wb_stb,
    input wire logic        wb_ack,
    input wire logic [11:0] analog_out_first_code,
    input wire logic [11:0] analog_out_second_code,
    input wire logic        outputs_active,
    input wire logic [1:0]  term_mode,
    input wire logic        exec_pulse,
    input wire logic        lead_bit_err
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic       sclk_q_ff;
    logic       nxt_sclk_q;
    logic [4:0] falls_ff;
    logic [4:0] nxt_falls;

    // Count falling link clock edges inside one frame
    always_comb begin
        nxt_sclk_q = sclk;
        nxt_falls  = falls_ff;
        if (sync_n) begin
            nxt_falls = 5'h00;
        end else if (sclk_q_ff && !sclk && falls_ff != 5'h1F) begin
            nxt_falls = falls_ff + 5'h01;
        end
    end

    // Edge history and fall counter
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sclk_q_ff <= 1'b1;
            falls_ff  <= 5'h00;
        end else begin
            sclk_q_ff <= nxt_sclk_q;
            falls_ff  <= nxt_falls;
        end
    end

    frame_len_a: assert property ($rose(sync_n) && falls_ff != 5'h00 |-> falls_ff == 5'h10)
        else $error("frame closed without sixteen clock falls");
    sync_fall_a: assert property ($fell(sync_n) |-> sclk && $past(sclk))
        else $error("frame select fell beside a clock fall");
    fall_in_frame_a: assert property ($fell(sclk) |-> !sync_n)
        else $error("clock fall outside a frame");
    din_hold_a: assert property ($fell(sclk) |=> $stable(din) [*3])
        else $error("data moved while clock low");
    exec_late_a: assert property (exec_pulse |-> !$past(sclk, 2))
        else $error("execution not tied to a clock fall");
    exec_once_a: assert property (exec_pulse |=> !exec_pulse)
        else $error("execution pulse too long");
    code_first_a: assert property ($changed(analog_out_first_code)
        |-> exec_pulse || $past(exec_pulse))
        else $error("first code changed without execution");
    code_second_a: assert property ($changed(analog_out_second_code)
        |-> exec_pulse || $past(exec_pulse))
        else $error("second code changed without execution");
    mode_exec_a: assert property ($changed(outputs_active) || $changed(term_mode)
        |-> exec_pulse || $past(exec_pulse))
        else $error("mode changed without execution");
    lead_err_a: assert property (lead_bit_err |-> exec_pulse)
        else $error("lead flag without execution");
    bus_ack_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack)
        else $error("bus answer late or long");

    // Main scenarios reached
    cover property (exec_pulse);
    cover property (lead_bit_err);
    cover property ($fell(outputs_active));
    cover property ($rose(outputs_active));
endmodule

// File: verification/dual_dac_serial_control_bench.sv
// Self-checking bench: bus master, frame model and a hand-driven second link
`timescale 1ns/100ps
module dual_dac_serial_control_bench;
    logic        clock;
    logic        rst_n;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic [11:0] analog_out_first_code;
    logic [11:0] analog_out_second_code;
    logic [11:0] code2_a;
    logic [11:0] code2_b;
    logic        outputs_active;
    logic        act2;
    logic [1:0]  term_mode;
    logic        exec_pulse;
    logic        lead_bit_err;
    logic [31:0] rd;
    logic [15:0] lfsr;
    logic        pd;
    int          fails, tests_run, n_exec, n_err, e_exec, e_err, tm;
    int          hold[2];
    int          outc[2];
    logic [15:0] dir[12] = '{16'h0123, 16'h4456, 16'h1789, 16'h2FFF, 16'h3000, 16'h7000,
                             16'hB000, 16'hF000, 16'h0555, 16'h9AAA, 16'h3000, 16'h5000};

    dsc_link_if lk ();
    dsc_link_if lk2 ();

    dsc_host i_dsc_host (.clock, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
                         .wb_dat_w, .wb_dat_r, .wb_ack, .link(lk));
    dsc_device i_dsc_device (.clock, .rst_n, .link(lk), .analog_out_first_code,
                             .analog_out_second_code, .outputs_active, .term_mode,
                             .exec_pulse, .lead_bit_err);
    dsc_device i_dsc_device_b (.clock, .rst_n, .link(lk2), .analog_out_first_code(code2_a),
                               .analog_out_second_code(code2_b), .outputs_active(act2),
                               .term_mode(), .exec_pulse(), .lead_bit_err());
    dsc_link_asserts i_dsc_link_asserts (.clock, .rst_n, .sclk(lk.sclk), .sync_n(lk.sync_n),
                                         .din(lk.din), .wb_cyc, .wb_stb, .wb_ack,
                                         .analog_out_first_code, .analog_out_second_code,
                                         .outputs_active, .term_mode, .exec_pulse,
                                         .lead_bit_err);

    // Free-running system clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Count execution and lead flag pulses
    always @(posedge clock) begin
        if (exec_pulse === 1'b1) n_exec++;
        if (lead_bit_err === 1'b1) n_err++;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic tally_and_finish;
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t out got %h exp %h", $time, got, exp);
        end
    endtask

    // One classic bus cycle, read data left in rd
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int i;
        i = 0;
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= dat;
        wb_sel <= 4'hF;
        @(posedge clock);
        while (wb_ack !== 1'b1 && i < 20) begin
            i++;
            @(posedge clock);
        end
        if (wb_ack !== 1'b1) begin
            fails++;
            tally_and_finish;
        end
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    // Compare device outputs with the model
    task automatic check;
        chk_out({20'h0, analog_out_first_code}, outc[0]);
        chk_out({20'h0, analog_out_second_code}, outc[1]);
        chk_out({31'h0, outputs_active}, {31'h0, !pd});
        if (pd) chk_out({30'h0, term_mode}, tm);
        chk_out(n_exec, e_exec);
        chk_out(n_err, e_err);
    endtask

    // Send one frame through the host, wait for idle, update the model
    task automatic cmd(input logic [15:0] f);
        int i;
        wb(1'b1, dsc_pkg::REG_CMD, {16'h0, f});
        rd = 32'h1;
        for (i = 0; i < 300 && rd[0] !== 1'b0; i++) wb(1'b0, dsc_pkg::REG_STATUS, 32'h0);
        if (rd[0] !== 1'b0) begin
            fails++;
            tally_and_finish;
        end
        e_exec++;
        if (f[13:12] == 2'h3) begin
            pd = 1'b1;
            tm = (f[15] ^ f[14]) ? f[15:14] : 0;
        end else begin
            pd = 1'b0;
            e_err += f[15];
            if (f[13:12] == 2'h2) hold = '{f[11:0], f[11:0]};
            else hold[f[14]] = f[11:0];
            if (f[13:12] != 2'h0) outc = hold;
        end
        check;
    endtask

    task automatic step;
        repeat (8) @(posedge clock);  // Half of a 64 ns link clock
    endtask

    // Hand-driven frame on the second link, n bits sent from b[n-1] down
    task automatic bb(input logic [31:0] b, input int n);
        int i;
        @(posedge clock);
        lk2.sync_n <= 1'b1;
        lk2.din <= 1'b0;
        step;
        lk2.sync_n <= 1'b0;
        lk2.din <= b[n-1];
        step;
        for (i = n - 1; i >= 0; i--) begin
            lk2.sclk <= 1'b0;
            step;
            lk2.sclk <= 1'b1;
            lk2.din <= (i > 0) ? b[i-1] : 1'b0;
            step;
        end
        lk2.sync_n <= 1'b1;
        step;
        lk2.sync_n <= 1'b0;
        step;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = '0;
        lk2.sclk = 1'b1;
        lk2.sync_n = 1'b0;
        lk2.din = 1'b0;
        {fails, tests_run, n_exec, n_err, e_exec, e_err, tm} = '0;
        hold = '{0, 0};
        outc = '{0, 0};
        pd = 1'b0;
        lfsr = 16'h0047;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        wb(1'b0, dsc_pkg::REG_DIV, 32'h0);
        chk_reg(rd, {24'h0, dsc_pkg::DIV_RESET});
        wb(1'b0, 8'h0C, 32'h0);
        chk_reg(rd, 32'h0);
        wb(1'b1, dsc_pkg::REG_DIV, {24'h0, dsc_pkg::DIV_MIN});
        wb(1'b0, dsc_pkg::REG_DIV, 32'h0);
        chk_reg(rd, {24'h0, dsc_pkg::DIV_MIN});
        check;
        foreach (dir[i]) cmd(dir[i]);
        wb(1'b0, dsc_pkg::REG_CMD, 32'h0);
        chk_reg(rd, {16'h0, dir[11]});
        repeat (12) begin
            lfsr = lfsr_next(lfsr);
            cmd(lfsr);
        end
        bb({16'h0, 16'h2ABC}, 16);
        chk_out({20'h0, code2_b}, 32'hABC);
        bb({22'h0, 10'(16'h2123 >> 6)}, 10);
        chk_out({20'h0, code2_a}, 32'hABC);
        bb({16'h2456, 16'h2789}, 32);
        chk_out({20'h0, code2_a}, 32'h456);
        bb({16'h0, 16'h7000}, 16);
        chk_out({31'h0, act2}, 32'h0);
        chk_out({20'h0, code2_a}, 32'h456);
        bb({16'h0, 16'h2DEF}, 16);
        chk_out({20'h0, code2_b}, 32'hDEF);
        chk_out({31'h0, act2}, 32'h1);
        tally_and_finish;
    end
endmodule
